// ==== rtl/dftd_defs.vh ====
// constants for the device frame transport dispatcher
// assumes includers use verilog-2005 or systemverilog and the macros below unchanged
`ifndef DFTD_DEFS_VH
`define DFTD_DEFS_VH

// ****************************************************
// application request codes
// ****************************************************
`define DFTD_REQ_REG     3'h0
`define DFTD_REQ_SDB     3'h1
`define DFTD_REQ_PIO     3'h2
`define DFTD_REQ_DMAACT  3'h3
`define DFTD_REQ_FPDMA   3'h4
`define DFTD_REQ_DATA    3'h5
`define DFTD_REQ_BIST    3'h6

// ****************************************************
// frame type field values
// ****************************************************
`define DFTD_FIS_REG_H2D 8'h27
`define DFTD_FIS_REG_D2H 8'h34
`define DFTD_FIS_SDB     8'hA1
`define DFTD_FIS_DATA    8'h46
`define DFTD_FIS_DMASTUP 8'h41
`define DFTD_FIS_BIST    8'h58

// ****************************************************
// frame lengths in dwords and field positions
// ****************************************************
`define DFTD_LEN_REG     3'h5
`define DFTD_LEN_SDB     3'h2
`define DFTD_POS_INTR    14
`define DFTD_POS_STATUS  16
`define DFTD_POS_ERROR   24

`endif

// ==== rtl/dftd_frame_mem.v ====
// staging memory for one outgoing frame, one dword per entry
// assumes a single writer and reader on one clock; read data is registered
`timescale 1ns/1ps
module dftd_frame_mem #(
  parameter WIDTH     = 32,
  parameter ADDR_BITS = 3
) (
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 wrEn,
  input  wire [ADDR_BITS-1:0] wrAddr,
  input  wire [WIDTH-1:0]     wrData,
  input  wire [ADDR_BITS-1:0] rdAddr,
  output reg  [WIDTH-1:0]     rdData
);

  reg [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // one cycle read latency; the reader waits a cycle after each address
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= {WIDTH{1'b0}};
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule // dftd_frame_mem

// ==== rtl/dftd_transport.v ====
// device transport dispatcher: idle wait, frame type check, register and
// set-device-bits frame builders with outcome wait and retry
// assumes link layer and application logic run on clk; other frame paths
// are delegated through extGo/extDone
`timescale 1ns/1ps
`include "dftd_defs.vh"

// How it works
// [R1] in wait, hold until an application request or an incoming frame start
// [R2] register frame request from wait goes to register build state
// [R3] set-device-bits request from wait goes to device-bits build state
// [R4] PIO setup request from wait goes to PIO setup build state
// [R5] DMA activate request from wait goes to DMA activate build state
// [R6] first-party DMA setup request goes to its build state
// [R7] data frame request from wait goes to data-to-host transmit state
// [R8] BIST activate request from wait goes to self-test transmit state
// [R9] link frame-start in wait enters type check on the received type
// [R10] host register frame in type check goes to register-from-host state
// [R11] host data frame in type check goes to data-from-host state
// [R12] DMA setup frame in type check goes to DMA setup receive state
// [R13] BIST frame in type check goes to self-test receive state
// [R14] unknown type or illegal-transition in type check returns to wait
// [R15] register build assembles frame, flags it pending, hands it to link
// [R16] device-bits build assembles frame, flags it pending, hands it over
// [R17] after last dword, signal transmit done and go to outcome wait
// [R18] outcome wait holds for link ending status then handles errors
// [R19] good ending status returns to wait
// [R20] bad ending status reports to link and rebuilds same frame type
// [R21] illegal-transition in register build abandons frame, back to wait
// [R22] after PIO setup exactly one data frame follows, direction by flag; only a to-host data request is refused while a to-device frame is owed
// [R23] illegal-transition in device-bits build abandons frame, back to wait
module dftd_transport #(
  parameter ADDR_BITS = 3
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        appTxReq,
  input  wire [2:0]  appTxType,
  input  wire        appPioToDev,
  input  wire [7:0]  appStatus,
  input  wire [7:0]  appError,
  input  wire [7:0]  appDevice,
  input  wire [47:0] appLba,
  input  wire [15:0] appCount,
  input  wire        appIntr,
  output wire        appTxAck,
  output reg  [3:0]  stateCode_reg,
  output reg         extGo_reg,
  input  wire        extDone,
  output reg         pioDataDue_reg,
  output reg         pioDataToDev_reg,
  input  wire        linkRxStart,
  input  wire [7:0]  linkRxType,
  input  wire        linkIllegal,
  output wire        linkTxPending,
  output reg  [31:0] linkTxData_reg,
  output reg         linkTxValid_reg,
  input  wire        linkTxReady,
  output reg         linkTxDone_reg,
  input  wire        linkEndValid,
  input  wire        linkEndErr,
  output reg         linkStatusReport_reg
);

  // ****************************************************
  // state codes
  // ****************************************************
  localparam S_WAIT     = 4'h0;
  localparam S_TYPECHK  = 4'h1;
  localparam S_REGBLD   = 4'h2;
  localparam S_SDBBLD   = 4'h3;
  localparam S_PIOBLD   = 4'h4;
  localparam S_DMAACT   = 4'h5;
  localparam S_FPDMA    = 4'h6;
  localparam S_DATATX   = 4'h7;
  localparam S_BISTTX   = 4'h8;
  localparam S_REGRX    = 4'h9;
  localparam S_DATARX   = 4'hA;
  localparam S_FPDMARX  = 4'hB;
  localparam S_BISTRX   = 4'hC;
  localparam S_OUTCOME  = 4'hD;

  // builder sub-phases
  localparam P_FILL  = 2'h0;
  localparam P_FETCH = 2'h1;
  localparam P_LOAD  = 2'h2;
  localparam P_SEND  = 2'h3;

  // ****************************************************
  // helpers
  // ****************************************************
  function isDelegated;
    input [3:0] st;
    begin
      case (st)
        S_PIOBLD, S_DMAACT, S_FPDMA, S_DATATX, S_BISTTX,
        S_REGRX, S_DATARX, S_FPDMARX, S_BISTRX: isDelegated = 1'b1;
        default:                               isDelegated = 1'b0;
      endcase
    end
  endfunction

  function isBuild;
    input [3:0] st;
    begin
      isBuild = (st == S_REGBLD) || (st == S_SDBBLD);
    end
  endfunction

  reg  [3:0]           state_next;
  reg  [1:0]           phase_reg;
  reg  [1:0]           phase_next;
  reg  [ADDR_BITS-1:0] idx_reg;
  reg  [ADDR_BITS-1:0] idx_next;
  reg                  sdbKind_reg;
  reg  [7:0]           rxType_reg;
  reg  [7:0]           latStatus_reg;
  reg  [7:0]           latError_reg;
  reg  [7:0]           latDevice_reg;
  reg  [47:0]          latLba_reg;
  reg  [15:0]          latCount_reg;
  reg                  latIntr_reg;
  reg                  latPioDir_reg;
  reg                  reqTake;
  reg  [31:0]          fillWord;
  wire [31:0]          memRdData;
  wire [ADDR_BITS-1:0] frameLast;
  wire                 dataBlocked;

  // frame words are built from content latched when the request is taken,
  // so a retry resends the same frame even if the application moves on
  always @* begin
    fillWord = 32'h0000_0000;
    if (sdbKind_reg) begin
      if (idx_reg == {ADDR_BITS{1'b0}}) begin
        fillWord[7:0]                    = `DFTD_FIS_SDB;
        fillWord[`DFTD_POS_INTR]         = latIntr_reg;
        fillWord[`DFTD_POS_STATUS+:8]    = latStatus_reg;
        fillWord[`DFTD_POS_ERROR+:8]     = latError_reg;
      end
    end else begin
      case (idx_reg)
        3'd0: begin
          fillWord[7:0]                  = `DFTD_FIS_REG_D2H;
          fillWord[`DFTD_POS_INTR]       = latIntr_reg;
          fillWord[`DFTD_POS_STATUS+:8]  = latStatus_reg;
          fillWord[`DFTD_POS_ERROR+:8]   = latError_reg;
        end
        3'd1:    fillWord = {latDevice_reg, latLba_reg[23:0]};
        3'd2:    fillWord = {8'h00, latLba_reg[47:24]};
        3'd3:    fillWord = {16'h0000, latCount_reg};
        default: fillWord = 32'h0000_0000;
      endcase
    end
  end

  assign frameLast = sdbKind_reg ? (`DFTD_LEN_SDB - 3'd1) : (`DFTD_LEN_REG - 3'd1);

  // ****************************************************
  // frame staging memory
  // ****************************************************
  dftd_frame_mem #(
    .WIDTH     (32),
    .ADDR_BITS (ADDR_BITS)
  ) u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (isBuild(stateCode_reg) && (phase_reg == P_FILL)), // [R15] [R16]
    .wrAddr (idx_reg),
    .wrData (fillWord),
    .rdAddr (idx_reg),
    .rdData (memRdData)
  );

  // pending is raised once assembly is done and held until the last dword
  assign linkTxPending = isBuild(stateCode_reg) && (phase_reg != P_FILL); // [R15] [R16]

  // a data frame toward the host is not taken while the PIO setup just sent
  // promised a frame toward the device
  assign dataBlocked = pioDataDue_reg && pioDataToDev_reg;                 // [R22]
  assign appTxAck    = reqTake;

  // ****************************************************
  // next state
  // ****************************************************
  always @* begin
    state_next = stateCode_reg;
    phase_next = phase_reg;
    idx_next   = idx_reg;
    reqTake    = 1'b0;
    case (stateCode_reg)
      S_WAIT: begin
        // a frame the host is already sending cannot wait; it wins
        if (linkRxStart) begin
          state_next = S_TYPECHK;                                          // [R9]
        end else if (appTxReq) begin                                       // [R1]
          reqTake = 1'b1;
          case (appTxType)
            `DFTD_REQ_REG:    state_next = S_REGBLD;                       // [R2]
            `DFTD_REQ_SDB:    state_next = S_SDBBLD;                       // [R3]
            `DFTD_REQ_PIO:    state_next = S_PIOBLD;                       // [R4]
            `DFTD_REQ_DMAACT: state_next = S_DMAACT;                       // [R5]
            `DFTD_REQ_FPDMA:  state_next = S_FPDMA;                        // [R6]
            `DFTD_REQ_DATA: begin
              if (dataBlocked) begin
                reqTake = 1'b0;
              end else begin
                state_next = S_DATATX;                                     // [R7]
              end
            end
            `DFTD_REQ_BIST:   state_next = S_BISTTX;                       // [R8]
            default:          reqTake = 1'b0;
          endcase
          phase_next = P_FILL;
          idx_next   = {ADDR_BITS{1'b0}};
        end
      end
      S_TYPECHK: begin
        if (linkIllegal) begin
          state_next = S_WAIT;                                             // [R14]
        end else begin
          case (rxType_reg)
            `DFTD_FIS_REG_H2D: state_next = S_REGRX;                       // [R10]
            `DFTD_FIS_DATA:    state_next = S_DATARX;                      // [R11]
            `DFTD_FIS_DMASTUP: state_next = S_FPDMARX;                     // [R12]
            `DFTD_FIS_BIST:    state_next = S_BISTRX;                      // [R13]
            default:           state_next = S_WAIT;                        // [R14]
          endcase
        end
      end
      S_REGBLD, S_SDBBLD: begin
        if (linkIllegal) begin
          state_next = S_WAIT;                                             // [R21] [R23]
        end else begin
          case (phase_reg)
            P_FILL: begin
              if (idx_reg == frameLast) begin
                phase_next = P_FETCH;
                idx_next   = {ADDR_BITS{1'b0}};
              end else begin
                idx_next = idx_reg + 1'b1;
              end
            end
            P_FETCH: phase_next = P_LOAD;
            P_LOAD:  phase_next = P_SEND;
            P_SEND: begin
              if (linkTxReady) begin
                if (idx_reg == frameLast) begin
                  state_next = S_OUTCOME;                                  // [R17]
                end else begin
                  idx_next   = idx_reg + 1'b1;
                  phase_next = P_FETCH;
                end
              end
            end
            default: phase_next = P_FILL;
          endcase
        end
      end
      S_OUTCOME: begin
        if (linkEndValid) begin                                            // [R18]
          if (linkEndErr) begin
            state_next = sdbKind_reg ? S_SDBBLD : S_REGBLD;                // [R20]
            phase_next = P_FILL;
            idx_next   = {ADDR_BITS{1'b0}};
          end else begin
            state_next = S_WAIT;                                           // [R19]
          end
        end
      end
      default: begin
        // delegated paths hand back on completion or a link abort
        if (isDelegated(stateCode_reg)) begin
          if (extDone || linkIllegal) begin
            state_next = S_WAIT;
          end
        end else begin
          state_next = S_WAIT;
        end
      end
    endcase
  end

  // ****************************************************
  // state and control registers
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateCode_reg        <= S_WAIT;
      phase_reg            <= P_FILL;
      idx_reg              <= {ADDR_BITS{1'b0}};
      extGo_reg            <= 1'b0;
      linkTxDone_reg       <= 1'b0;
      linkStatusReport_reg <= 1'b0;
      rxType_reg           <= 8'h00;
    end else begin
      stateCode_reg        <= state_next;
      phase_reg            <= phase_next;
      idx_reg              <= idx_next;
      extGo_reg            <= isDelegated(state_next) && (state_next != stateCode_reg);
      linkTxDone_reg       <= isBuild(stateCode_reg) && (state_next == S_OUTCOME); // [R17]
      linkStatusReport_reg <= (stateCode_reg == S_OUTCOME) && linkEndValid
                              && linkEndErr;                               // [R20]
      if ((stateCode_reg == S_WAIT) && linkRxStart) begin
        rxType_reg <= linkRxType;                                          // [R9]
      end
    end
  end

  // ****************************************************
  // latched request content
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdbKind_reg   <= 1'b0;
      latStatus_reg <= 8'h00;
      latError_reg  <= 8'h00;
      latDevice_reg <= 8'h00;
      latLba_reg    <= 48'h0000_0000_0000;
      latCount_reg  <= 16'h0000;
      latIntr_reg   <= 1'b0;
      latPioDir_reg <= 1'b0;
    end else if (reqTake) begin
      sdbKind_reg   <= (appTxType == `DFTD_REQ_SDB);
      latStatus_reg <= appStatus;
      latError_reg  <= appError;
      latDevice_reg <= appDevice;
      latLba_reg    <= appLba;
      latCount_reg  <= appCount;
      latIntr_reg   <= appIntr;
      latPioDir_reg <= appPioToDev;
    end
  end

  // ****************************************************
  // link transmit data
  // ****************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkTxData_reg  <= 32'h0000_0000;
      linkTxValid_reg <= 1'b0;
    end else if (linkIllegal || !isBuild(stateCode_reg)) begin
      linkTxValid_reg <= 1'b0;
    end else if (phase_reg == P_LOAD) begin
      linkTxData_reg  <= memRdData;                                        // [R15] [R16]
      linkTxValid_reg <= 1'b1;
    end else if ((phase_reg == P_SEND) && linkTxReady) begin
      linkTxValid_reg <= 1'b0;
    end
  end

  // ****************************************************
  // PIO data frame expectation
  // ****************************************************
  // raised when a PIO setup path completes cleanly, dropped by the one data
  // frame that follows in either direction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pioDataDue_reg   <= 1'b0;
      pioDataToDev_reg <= 1'b0;
    end else if ((stateCode_reg == S_PIOBLD) && extDone && !linkIllegal) begin
      pioDataDue_reg   <= 1'b1;                                            // [R22]
      pioDataToDev_reg <= latPioDir_reg;
    end else if (((state_next == S_DATATX) || (state_next == S_DATARX))
                 && (state_next != stateCode_reg)) begin
      pioDataDue_reg   <= 1'b0;                                            // [R22]
    end
  end

endmodule // dftd_transport

// ==== testbench/dftd_chk.sv ====
// port assertions for the transport dispatcher
// assumes it is bound onto dftd_transport and sees only its ports
`timescale 1ns/1ps
`include "dftd_defs.vh"
module dftd_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        appTxReq,
  input wire [2:0]  appTxType,
  input wire        appTxAck,
  input wire [3:0]  stateCode_reg,
  input wire        linkRxStart,
  input wire [7:0]  linkRxType,
  input wire        linkIllegal,
  input wire        linkTxPending,
  input wire [31:0] linkTxData_reg,
  input wire        linkTxValid_reg,
  input wire        linkTxReady,
  input wire        linkTxDone_reg,
  input wire        linkEndValid,
  input wire        linkEndErr,
  input wire        pioDataDue_reg,
  input wire        pioDataToDev_reg
);
  reg [7:0] rxType_reg;

  // type is only valid in the start cycle, so keep it for the check state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rxType_reg <= 8'h00;
    else if (stateCode_reg == 4'h0 && linkRxStart)
      rxType_reg <= linkRxType;
  end

  function [3:0] rxDest(input [7:0] t);
    case (t)
      `DFTD_FIS_REG_H2D: rxDest = 4'h9;
      `DFTD_FIS_DATA:    rxDest = 4'hA;
      `DFTD_FIS_DMASTUP: rxDest = 4'hB;
      `DFTD_FIS_BIST:    rxDest = 4'hC;
      default:           rxDest = 4'h0;
    endcase
  endfunction

  // ********
  // assertions
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  wait_hold_a:
    assert property (stateCode_reg == 4'h0 && !appTxReq && !linkRxStart |=> stateCode_reg == 4'h0)
    else $error("wait state left without cause");
  tx_route_a:
    assert property (appTxAck |-> stateCode_reg == 4'h0 ##1 stateCode_reg == $past(appTxType) + 4'h2)
    else $error("request routed to wrong state");
  rx_enter_a:
    assert property (stateCode_reg == 4'h0 && linkRxStart |=> stateCode_reg == 4'h1)
    else $error("frame start did not enter type check");
  rx_route_a:
    assert property (stateCode_reg == 4'h1 && !linkIllegal |=> stateCode_reg == rxDest(rxType_reg))
    else $error("received type routed to wrong state");
  chk_illegal_a:
    assert property (stateCode_reg == 4'h1 && linkIllegal |=> stateCode_reg == 4'h0)
    else $error("illegal notice in type check ignored");
  tx_hold_a:
    assert property (linkTxValid_reg && !linkTxReady && !linkIllegal |-> linkTxPending
      ##1 linkTxValid_reg && $stable(linkTxData_reg)) else $error("dword not held");
  tx_done_a:
    assert property (linkTxDone_reg |-> stateCode_reg == 4'hD
      && $past(linkTxValid_reg && linkTxReady) ##1 !linkTxDone_reg) else $error("bad done");
  end_ok_a:
    assert property (stateCode_reg == 4'hD && linkEndValid && !linkEndErr |=> stateCode_reg == 4'h0)
    else $error("good status did not return to wait");
  end_retry_a:
    assert property (stateCode_reg == 4'hD && linkEndValid && linkEndErr |=>
      (stateCode_reg == 4'h2 || stateCode_reg == 4'h3)) else $error("no retry after error");
  bld_abort_a:
    assert property ((stateCode_reg == 4'h2 || stateCode_reg == 4'h3) && linkIllegal
      |=> stateCode_reg == 4'h0 && !linkTxValid_reg) else $error("build not abandoned");
  outcome_hold_a:
    assert property (stateCode_reg == 4'hD && !linkEndValid |=> stateCode_reg == 4'hD)
    else $error("outcome wait left without ending status");
  data_block_a:
    assert property (pioDataDue_reg && pioDataToDev_reg && appTxReq
      && appTxType == `DFTD_REQ_DATA |-> !appTxAck) else $error("data sent against owed frame");
endmodule // dftd_chk

// ==== testbench/dftd_link_model.sv ====
// behavioural link layer on the transmit side of the dispatcher
// assumes one clock; ending status follows each finished frame
`timescale 1ns/1ps
module dftd_link_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        txValid,
  input  wire [31:0] txData,
  input  wire        txDone,
  input  wire        slow,
  input  wire        errNext,
  output reg         ready,
  output reg         endValid,
  output reg         endErr
);
  reg [31:0] cap [0:7];
  reg [3:0]  capN;
  reg [2:0]  endCnt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready    <= 1'b0;
      endValid <= 1'b0;
      endErr   <= 1'b0;
      capN     <= 4'h0;
      endCnt   <= 3'h0;
    end else begin
      // slow mode stalls every other cycle so held dwords get exercised
      ready <= slow ? ~ready : 1'b1;
      if (txValid && ready) begin
        cap[capN[2:0]] <= txData;
        capN           <= capN + 4'h1;
      end
      if (txDone)
        endCnt <= 3'h3;
      else if (endCnt != 3'h0)
        endCnt <= endCnt - 3'h1;
      endValid <= (endCnt == 3'h1);
      // outside its valid cycle the error flag toggles, so it means nothing
      endErr <= (endCnt == 3'h1) ? errNext : ~endErr;
      if (endValid)
        capN <= 4'h0;
    end
  end
endmodule // dftd_link_model

// ==== testbench/tb.sv ====
// self-checking bench for the transport dispatcher
// assumes the link model answers transmit dwords and ending status
`timescale 1ns/1ps
`include "dftd_defs.vh"
module tb;
  reg         clk, rst_n, appTxReq, appPioToDev, appIntr, extDone;
  reg         linkRxStart, linkIllegal, slow, errNext;
  reg  [2:0]  appTxType;
  reg  [7:0]  appStatus, appError, appDevice, linkRxType;
  reg  [47:0] appLba;
  reg  [15:0] appCount;
  wire        appTxAck, extGo_reg, pioDataDue_reg, pioDataToDev_reg, linkTxPending;
  wire        linkTxValid_reg, linkTxReady, linkTxDone_reg, linkEndValid, linkEndErr;
  wire        linkStatusReport_reg;
  wire [3:0]  stateCode_reg;
  wire [31:0] linkTxData_reg;
  integer     num_errors, tests_run, nReport, i, c;

  dftd_transport dftd_transport_inst (.clk, .rst_n, .appTxReq, .appTxType, .appPioToDev,
    .appStatus, .appError, .appDevice, .appLba, .appCount, .appIntr, .appTxAck,
    .stateCode_reg, .extGo_reg, .extDone, .pioDataDue_reg, .pioDataToDev_reg,
    .linkRxStart, .linkRxType, .linkIllegal, .linkTxPending, .linkTxData_reg,
    .linkTxValid_reg, .linkTxReady, .linkTxDone_reg, .linkEndValid, .linkEndErr,
    .linkStatusReport_reg);
  dftd_link_model dftd_link_model_inst (.clk, .rst_n, .txValid(linkTxValid_reg),
    .txData(linkTxData_reg), .txDone(linkTxDone_reg), .slow, .errNext,
    .ready(linkTxReady), .endValid(linkEndValid), .endErr(linkEndErr));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (linkStatusReport_reg === 1'b1) nReport = nReport + 1;

  // ********
  // helpers
  // ********
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #5;
    end
  endtask
  task waitSt(input [3:0] s);
    integer k;
    begin
      for (k = 0; k < 80 && stateCode_reg !== s; k = k + 1)
        tick(1);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task sendReq(input [2:0] code, input ackExp);
    begin
      appTxType = code;
      appTxReq = 1'b1;
      #1;
      check(appTxAck, ackExp);
      tick(ackExp ? 1 : 3);
      appTxReq = 1'b0;
    end
  endtask
  task finishExt;
    begin
      if (stateCode_reg !== 4'h0) begin
        extDone = 1'b1;
        tick(1);
        extDone = 1'b0;
        waitSt(4'h0);
      end
      check(stateCode_reg, 4'h0);
    end
  endtask
  function [31:0] expWord(input sdb, input [2:0] n);
    case (n)
      3'h0: expWord = {appError, appStatus, 1'b0, appIntr, 6'h00,
                       sdb ? `DFTD_FIS_SDB : `DFTD_FIS_REG_D2H};
      3'h1: expWord = sdb ? 32'h0000_0000 : {appDevice, appLba[23:0]};
      3'h2: expWord = {8'h00, appLba[47:24]};
      3'h3: expWord = {16'h0000, appCount};
      default: expWord = 32'h0000_0000;
    endcase
  endfunction

  // ********
  // scenarios
  // ********
  task txFrame(input [2:0] code, input bad);
    integer pass;
    begin
      nReport = 0;
      sendReq(code, 1'b1);
      for (pass = 0; pass <= bad; pass = pass + 1) begin
        check(stateCode_reg, {1'b0, code} + 4'h2);
        waitSt(4'hD);
        check(linkTxDone_reg, 1'b1);
        for (i = 0; i < (code ? 2 : 5); i = i + 1)
          check(dftd_link_model_inst.cap[i], expWord(code[0], i[2:0]));
        errNext = bad && pass == 0;
        waitSt(errNext ? {1'b0, code} + 4'h2 : 4'h0);
        tick(2);
      end
      errNext = 1'b0;
      check(nReport, bad);
      check(stateCode_reg, 4'h0);
    end
  endtask
  task abortBuild(input [2:0] code);
    begin
      sendReq(code, 1'b1);
      tick(7);
      check(linkTxPending, 1'b1);
      linkIllegal = 1'b1;
      tick(1);
      linkIllegal = 1'b0;
      check(stateCode_reg, 4'h0);
      check(linkTxValid_reg, 1'b0);
      check(linkTxPending, 1'b0);
    end
  endtask
  task rxFrame(input [7:0] t, input [3:0] dest, input bad);
    begin
      linkRxStart = 1'b1;
      linkRxType = t;
      tick(1);
      linkRxStart = 1'b0;
      linkRxType = ~t;
      linkIllegal = bad;
      check(stateCode_reg, 4'h1);
      tick(1);
      linkIllegal = 1'b0;
      check(stateCode_reg, bad ? 4'h0 : dest);
      finishExt;
    end
  endtask
  task delegated;
    begin
      appPioToDev = 1'b0;
      for (c = 2; c <= 6; c = c + 1) begin
        sendReq(c[2:0], 1'b1);
        check(stateCode_reg, c[3:0] + 4'h2);
        check(extGo_reg, 1'b1);
        finishExt;
        if (c == 2)
          check({pioDataDue_reg, pioDataToDev_reg}, 2'b10);
      end
    end
  endtask
  task pioOwed;
    begin
      appPioToDev = 1'b1;
      sendReq(`DFTD_REQ_PIO, 1'b1);
      finishExt;
      check({pioDataDue_reg, pioDataToDev_reg}, 2'b11);
      sendReq(`DFTD_REQ_DATA, 1'b0);
      check(stateCode_reg, 4'h0);
      rxFrame(`DFTD_FIS_DATA, 4'hA, 1'b0);
      check(pioDataDue_reg, 1'b0);
    end
  endtask

  initial begin
    num_errors = 0;
    tests_run = 0;
    nReport = 0;
    rst_n = 1'b0;
    appTxReq = 1'b0;
    appTxType = 3'h0;
    appPioToDev = 1'b0;
    appIntr = 1'b1;
    extDone = 1'b0;
    linkRxStart = 1'b0;
    linkIllegal = 1'b0;
    slow = 1'b0;
    errNext = 1'b0;
    appStatus = 8'h50;
    appError = 8'h5A;
    appDevice = 8'h40;
    linkRxType = 8'h00;
    appLba = 48'h1234_5678_9ABC;
    appCount = 16'h0010;
    repeat (3) @(posedge clk);
    #5 rst_n = 1'b1;
    tick(1);
    txFrame(`DFTD_REQ_REG, 1'b0);
    slow = 1'b1;
    txFrame(`DFTD_REQ_SDB, 1'b1);
    abortBuild(`DFTD_REQ_REG);
    abortBuild(`DFTD_REQ_SDB);
    slow = 1'b0;
    sendReq(3'h7, 1'b0);
    check(stateCode_reg, 4'h0);
    delegated;
    pioOwed;
    rxFrame(`DFTD_FIS_REG_H2D, 4'h9, 1'b0);
    rxFrame(`DFTD_FIS_DMASTUP, 4'hB, 1'b0);
    rxFrame(`DFTD_FIS_BIST, 4'hC, 1'b0);
    rxFrame(8'h99, 4'h0, 1'b0);
    rxFrame(`DFTD_FIS_REG_H2D, 4'h9, 1'b1);
    complete_run;
  end

  // the whole run needs well under a thousand cycles; a hang stops here
  initial begin
    #(3000 * 50);
    num_errors = num_errors + 1;
    complete_run;
  end
endmodule // tb

bind dftd_transport dftd_chk dftd_chk_inst (.clk, .rst_n, .appTxReq, .appTxType, .appTxAck,
  .stateCode_reg, .linkRxStart, .linkRxType, .linkIllegal, .linkTxPending, .linkTxData_reg,
  .linkTxValid_reg, .linkTxReady, .linkTxDone_reg, .linkEndValid, .linkEndErr,
  .pioDataDue_reg, .pioDataToDev_reg);
